// ### rtl/serializer_config_alias_regs.sv
module serializer_config_alias_regs (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // local register port
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // pins
  input  wire logic       mode_pin,
  input  wire logic       rx_lock,
  // from control channel
  input  wire logic       bcc_addr_valid,
  input  wire logic [6:0] bcc_deser_addr,
  input  wire logic       bcc_mode_valid,
  input  wire logic [1:0] bcc_mode,
  // incoming i2c address to decode
  input  wire logic       i2c_req,
  input  wire logic [6:0] i2c_addr,
  // forwarding result
  output logic            fwd_valid,
  output logic [6:0]      fwd_addr,
  // block controls
  output logic            pll_src_direct,
  output logic            pixel_edge_select,
  output logic            mode_12bit,
  output logic            mode_10bit
);
  logic       lock_s;
  logic       pin_s;
  logic [7:0] gen_reg, gen_next;
  logic       movr_reg, movr_next;
  logic       cur_reg, cur_next;
  logic [1:0] mode_reg, mode_next;
  logic [6:0] daddr_reg, daddr_next;
  logic       dlock_reg, dlock_next;
  logic [6:0] dalias_reg, dalias_next;
  logic [6:0] taddr_reg, taddr_next;
  logic [6:0] talias_reg, talias_next;
  logic       psel_reg, psel_next;
  logic [7:0] rdata_reg, rdata_next;
  logic       fv_reg, fv_next;
  logic [6:0] fa_reg, fa_next;
  logic       pll_reg, pll_next;
  logic [1:0] rxmode_reg, rxmode_next;
  logic       wr_gen, wr_mode, wr_da, wr_dl, wr_ta, wr_tl, wr_ps;

  // pins come from outside the clock domain
  level_sync u_lock_sync (
    .clk   (clk),
    .reset (reset),
    .din   (rx_lock),
    .dout  (lock_s)
  );
  level_sync u_pin_sync (
    .clk   (clk),
    .reset (reset),
    .din   (mode_pin),
    .dout  (pin_s)
  );

  // write decode
  always_comb begin
    wr_gen = reg_wr && reg_addr == alias_regs_pkg::GEN_CFG_OFS;
    wr_mode = reg_wr && reg_addr == alias_regs_pkg::MODE_SEL_OFS;
    wr_da = reg_wr && reg_addr == alias_regs_pkg::DESER_ADDR_OFS;
    wr_dl = reg_wr && reg_addr == alias_regs_pkg::DESER_ALIAS_OFS;
    wr_ta = reg_wr && reg_addr == alias_regs_pkg::TGT_ADDR_OFS;
    wr_tl = reg_wr && reg_addr == alias_regs_pkg::TGT_ALIAS_OFS;
    wr_ps = reg_wr && reg_addr == alias_regs_pkg::PLL_SEL_OFS;
  end

  // register file next state
  always_comb begin
    gen_next    = gen_reg;
    movr_next   = movr_reg;
    daddr_next  = daddr_reg;
    dlock_next  = dlock_reg;
    dalias_next = dalias_reg;
    taddr_next  = taddr_reg;
    talias_next = talias_reg;
    psel_next   = psel_reg;
    rxmode_next = rxmode_reg;
    cur_next    = cur_reg;
    if (wr_gen) begin
      gen_next = reg_wdata; // upper bits belong to other logic
    end
    if (wr_mode) begin
      movr_next = reg_wdata[alias_regs_pkg::MODE_OVR_BIT];
    end
    // channel load first so a same-cycle software write wins
    if (lock_s && bcc_addr_valid && !dlock_reg) begin
      daddr_next = bcc_deser_addr;
    end
    if (wr_da) begin
      daddr_next = reg_wdata[7:1];
      dlock_next = reg_wdata[alias_regs_pkg::LOCK_BIT];
    end
    if (wr_dl) begin
      dalias_next = reg_wdata[7:1];
    end
    if (wr_ta) begin
      taddr_next = reg_wdata[7:1];
    end
    if (wr_tl) begin
      talias_next = reg_wdata[7:1];
    end
    if (wr_ps) begin
      psel_next = reg_wdata[alias_regs_pkg::PLL_SEL_BIT];
    end
    // received mode info; current until link lost
    if (bcc_mode_valid && lock_s) begin
      rxmode_next = bcc_mode;
      cur_next    = 1'b1;
    end else if (!lock_s) begin
      cur_next = 1'b0;
    end
  end

  // effective mode and pll source
  always_comb begin
    mode_next = rxmode_reg;
    if (movr_reg || !cur_reg) begin
      mode_next = alias_regs_pkg::MODE_NONE;
    end
    // override takes register choice, else the pin
    pll_next = gen_reg[alias_regs_pkg::OVR_BIT] ? psel_reg : pin_s;
  end

  // alias decode and remap
  always_comb begin
    fv_next = 1'b0;
    fa_next = fa_reg;
    if (i2c_req && gen_reg[alias_regs_pkg::PASS_BIT]) begin
      if (dalias_reg != 7'h00 && daddr_reg != 7'h00 &&
          i2c_addr == dalias_reg) begin
        fv_next = 1'b1;
        fa_next = daddr_reg;
      end else if (talias_reg != 7'h00 && taddr_reg != 7'h00 &&
                   i2c_addr == talias_reg) begin
        fv_next = 1'b1;
        fa_next = taddr_reg;
      end
    end
  end

  // read mux; reserved bits read zero
  always_comb begin
    rdata_next = rdata_reg;
    if (reg_rd) begin
      case (reg_addr)
        alias_regs_pkg::GEN_CFG_OFS:     rdata_next = gen_reg;
        alias_regs_pkg::MODE_SEL_OFS:    rdata_next = {2'h0, movr_reg,
          cur_reg, mode_reg, 2'h0};
        alias_regs_pkg::DESER_ADDR_OFS:  rdata_next = {daddr_reg, dlock_reg};
        alias_regs_pkg::DESER_ALIAS_OFS: rdata_next = {dalias_reg, 1'b0};
        alias_regs_pkg::TGT_ADDR_OFS:    rdata_next = {taddr_reg, 1'b0};
        alias_regs_pkg::TGT_ALIAS_OFS:   rdata_next = {talias_reg, 1'b0};
        alias_regs_pkg::PLL_SEL_OFS:     rdata_next = {7'h00, psel_reg};
        default:                         rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      gen_reg    <= alias_regs_pkg::GEN_CFG_RST;
      movr_reg   <= 1'b0;
      cur_reg    <= 1'b0;
      mode_reg   <= alias_regs_pkg::MODE_NONE;
      rxmode_reg <= alias_regs_pkg::MODE_NONE;
      daddr_reg  <= 7'h00;
      dlock_reg  <= 1'b0;
      dalias_reg <= 7'h00;
      taddr_reg  <= 7'h00;
      talias_reg <= 7'h00;
      psel_reg   <= 1'b0;
      rdata_reg  <= alias_regs_pkg::ZERO_RST;
      fv_reg     <= 1'b0;
      fa_reg     <= 7'h00;
      pll_reg    <= 1'b0;
    end else begin
      gen_reg    <= gen_next;
      movr_reg   <= movr_next;
      cur_reg    <= cur_next;
      mode_reg   <= mode_next;
      rxmode_reg <= rxmode_next;
      daddr_reg  <= daddr_next;
      dlock_reg  <= dlock_next;
      dalias_reg <= dalias_next;
      taddr_reg  <= taddr_next;
      talias_reg <= talias_next;
      psel_reg   <= psel_next;
      rdata_reg  <= rdata_next;
      fv_reg     <= fv_next;
      fa_reg     <= fa_next;
      pll_reg    <= pll_next;
    end
  end

  assign reg_rdata         = rdata_reg;
  assign fwd_valid         = fv_reg;
  assign fwd_addr          = fa_reg;
  assign pll_src_direct    = pll_reg;
  assign pixel_edge_select = gen_reg[alias_regs_pkg::EDGE_BIT];
  assign mode_12bit        = mode_reg[1];
  assign mode_10bit        = mode_reg[0];
endmodule

// ### include/alias_regs_pkg.sv
// Behaviour
// - override set: pll source from register
// - override clear: pll source from pin
// - edge select 1 rising, 0 falling
// - mode override ignores received mode bits
// - read-only flag: received mode info current
// - read-only bit3: 12-bit mode active
// - read-only bit2: 10-bit mode active
// - deser address reset zero, zero blocks access
// - auto-load deser address after receive lock
// - address lock bit stops auto-load
// - deser alias match remaps to deser address
// - target address reset zero, zero blocks
// - target alias match remaps to target address
// - target alias field, zero disables
// - forwarding only while pass-through enabled
package alias_regs_pkg;
  // register offsets
  localparam logic [7:0] GEN_CFG_OFS     = 8'h03;
  localparam logic [7:0] MODE_SEL_OFS    = 8'h05;
  localparam logic [7:0] DESER_ADDR_OFS  = 8'h06;
  localparam logic [7:0] DESER_ALIAS_OFS = 8'h07;
  localparam logic [7:0] TGT_ADDR_OFS    = 8'h08;
  localparam logic [7:0] TGT_ALIAS_OFS   = 8'h09;
  localparam logic [7:0] PLL_SEL_OFS     = 8'h35;
  // field positions
  localparam int PASS_BIT     = 2;
  localparam int OVR_BIT      = 1;
  localparam int EDGE_BIT     = 0;
  localparam int MODE_OVR_BIT = 5;
  localparam int CURRENT_BIT  = 4;
  localparam int M12_BIT      = 3;
  localparam int M10_BIT      = 2;
  localparam int LOCK_BIT     = 0;
  localparam int PLL_SEL_BIT  = 0;
  // reset values
  localparam logic [7:0] GEN_CFG_RST  = 8'h05;
  localparam logic [7:0] MODE_SEL_RST = 8'h00;
  localparam logic [7:0] ZERO_RST     = 8'h00;
  // mode codes: bit1 = 12-bit high freq, bit0 = 10-bit
  localparam logic [1:0] MODE_NONE = 2'h0;
  // synchroniser depth
  localparam int SYNC_STAGES = 3;
endpackage

// ### rtl/level_sync.sv
module level_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // level
  input  wire logic din,
  output logic      dout
);
  logic [alias_regs_pkg::SYNC_STAGES-1:0] sh_reg;
  logic [alias_regs_pkg::SYNC_STAGES-1:0] sh_next;
  logic                                   out_reg;
  logic                                   out_next;

  // accept a change once the last two stages agree
  always_comb begin
    sh_next  = {sh_reg[alias_regs_pkg::SYNC_STAGES-2:0], din};
    out_next = out_reg;
    if (sh_reg[2] == sh_reg[1]) begin
      out_next = sh_reg[2];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sh_reg  <= '0;
      out_reg <= 1'b0;
    end else begin
      sh_reg  <= sh_next;
      out_reg <= out_next;
    end
  end

  assign dout = out_reg;
endmodule

// ### testbench/serializer_config_alias_regs_sva.sv
module cfg_alias_sva (
  // watched ports
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       i2c_req,
  input wire logic [6:0] i2c_addr,
  input wire logic       fwd_valid,
  input wire logic [6:0] fwd_addr,
  input wire logic       pll_src_direct,
  input wire logic       pixel_edge_select,
  input wire logic       mode_12bit,
  input wire logic       mode_10bit
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // forwarding only ever answers a request
  fwd_cause_a: assert property (fwd_valid |-> $past(i2c_req))
    else $error("forward without request");
  zero_alias_a: assert property (i2c_req && i2c_addr == 7'h00
    |=> !fwd_valid) else $error("zero alias forwarded");
  zero_dest_a: assert property (fwd_valid |-> fwd_addr != 7'h00)
    else $error("forward to zero");
  edge_wr_a: assert property (reg_wr && reg_addr == 8'h03
    |-> ##2 pixel_edge_select == $past(reg_wdata[0], 2))
    else $error("edge select not taken");
  unmapped_a: assert property (reg_rd && reg_addr == 8'h0A
    |=> reg_rdata == 8'h00) else $error("unmapped read");
  alias_rsvd_a: assert property (reg_rd && reg_addr == 8'h07
    |=> !reg_rdata[0]) else $error("alias bit0 set");
  mode_rsvd_a: assert property (reg_rd && reg_addr == 8'h05
    |=> reg_rdata[1:0] == 2'h0) else $error("mode low bits set");
  // levels right out of reset
  reset_vals_a: assert property ($fell(reset) |-> pixel_edge_select
    && !pll_src_direct && !mode_12bit && !mode_10bit)
    else $error("bad levels after reset");
endmodule

bind serializer_config_alias_regs cfg_alias_sva chk_u (
  .clk(clk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .i2c_req(i2c_req), .i2c_addr(i2c_addr), .fwd_valid(fwd_valid),
  .fwd_addr(fwd_addr), .pll_src_direct(pll_src_direct),
  .pixel_edge_select(pixel_edge_select), .mode_12bit(mode_12bit),
  .mode_10bit(mode_10bit));

// ### testbench/deser_partner.sv
module deser_partner (
  // clock and channel outputs
  input  wire logic       clk,
  output logic            rx_lock,
  output logic            a_v,
  output logic            m_v,
  output logic      [6:0] a,
  output logic      [1:0] m
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {rx_lock, a_v, m_v, a, m} = 12'h0AA;
  // lock settles before the first id is delivered
  task send(input logic [6:0] ad, input logic [1:0] md);
    if (!rx_lock) begin
      @(posedge clk);
      rx_lock <= 1'b1;
      repeat (6) @(posedge clk);
    end
    @(posedge clk);
    {a_v, m_v, a, m} <= {2'h3, ad, md};
    @(posedge clk);
    // released lines flip so a stale value never looks fresh
    {a_v, m_v, a, m} <= {2'h0, ~ad, ~md};
  endtask
endmodule

// ### testbench/test_serializer_config_alias_regs.sv
module test_serializer_config_alias_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset, reg_wr, reg_rd, mode_pin, i2c_req, rx_lock;
  logic a_v, m_v, fwd_valid, pll_src_direct, pixel_edge_select;
  logic mode_12bit, mode_10bit;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [6:0] i2c_addr, fwd_addr, a;
  logic [1:0] m;
  logic [31:0] seed;
  int n_mismatch, n_tests, cyc, pass, da, dd, ta, tt, e;
  // device and far-side model
  serializer_config_alias_regs dut_u (.clk(clk), .reset(reset),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .mode_pin(mode_pin),
    .rx_lock(rx_lock), .bcc_addr_valid(a_v), .bcc_deser_addr(a),
    .bcc_mode_valid(m_v), .bcc_mode(m), .i2c_req(i2c_req),
    .i2c_addr(i2c_addr), .fwd_valid(fwd_valid), .fwd_addr(fwd_addr),
    .pll_src_direct(pll_src_direct),
    .pixel_edge_select(pixel_edge_select), .mode_12bit(mode_12bit),
    .mode_10bit(mode_10bit));
  deser_partner par_u (.clk(clk), .rx_lock(rx_lock), .a_v(a_v),
    .m_v(m_v), .a(a), .m(m));
  function logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  task wrap_up();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [7:0] g, input logic [7:0] x);
    n_tests++;
    if (g !== x) begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, g, x);
    end
  endtask
  // register cycles: strobe held for exactly one edge
  task wr(input logic [7:0] ad, input logic [7:0] wd);
    @(posedge clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, ad, wd};
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] ad, input logic [7:0] x);
    @(posedge clk);
    {reg_rd, reg_addr} <= {1'b1, ad};
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, x);
  endtask
  // expected remap from the bench's own copy of the map
  task req(input logic [6:0] ad);
    @(posedge clk);
    {i2c_req, i2c_addr} <= {1'b1, ad};
    @(posedge clk);
    i2c_req <= 1'b0;
    e = 0;
    if (pass && da != 0 && ad == da && dd != 0) e = dd + 128;
    else if (pass && ta != 0 && ad == ta && tt != 0) e = tt + 128;
    #1 chk({fwd_valid, e[7] ? fwd_addr : 7'h00}, e[7:0]);
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // cycle ceiling cuts a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial begin
    {reset, reg_wr, reg_rd, mode_pin, i2c_req} = 5'h10;
    {reg_addr, reg_wdata, i2c_addr} = 23'h0;
    {pass, da, dd, ta, tt} = {32'h1, 128'h0};
    seed = 32'h5177F12E;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    rd(8'h03, 8'h05);
    for (int i = 5; i < 10; i++) rd(8'(i), 8'h00);
    rd(8'h0A, 8'h00);
    // id loads once locked, mode info turns current
    par_u.send(7'h12, 2'h2);
    repeat (4) @(posedge clk);
    chk({6'h0, mode_12bit, mode_10bit}, 8'h02);
    rd(8'h06, 8'h24);
    rd(8'h05, 8'h18);
    par_u.send(7'h13, 2'h1);
    repeat (4) @(posedge clk);
    chk({6'h0, mode_12bit, mode_10bit}, 8'h01);
    rd(8'h05, 8'h14);
    wr(8'h05, 8'h20);
    par_u.send(7'h14, 2'h2);
    repeat (4) @(posedge clk);
    chk({6'h0, mode_12bit, mode_10bit}, 8'h00);
    rd(8'h05, 8'h30);
    wr(8'h06, 8'h51);
    par_u.send(7'h15, 2'h1);
    rd(8'h06, 8'h51);
    dd = 'h28;
    wr(8'h07, 8'h60);
    wr(8'h08, 8'h44);
    {da, tt} = {32'h30, 32'h22};
    req(7'h00);
    wr(8'h09, 8'h70);
    ta = 'h38;
    for (int i = 0; i < 40; i++) begin
      seed = xs(seed);
      req(seed[2] ? seed[9:3] : (seed[1] ? 7'h38 : 7'h30));
    end
    wr(8'h08, 8'h00);
    tt = 0;
    req(7'h38);
    wr(8'h03, 8'h00);
    pass = 0;
    req(7'h30);
    chk({7'h0, pixel_edge_select}, 8'h00);
    // pin changes only on a rising edge, like every other input
    @(posedge clk);
    mode_pin <= 1'b1;
    repeat (6) @(posedge clk);
    chk({7'h0, pll_src_direct}, 8'h01);
    wr(8'h35, 8'h00);
    wr(8'h03, 8'h02);
    repeat (3) @(posedge clk);
    chk({7'h0, pll_src_direct}, 8'h00);
    wrap_up();
  end
endmodule
